// [ee_map.svh]
`ifndef EE_MAP_SVH
`define EE_MAP_SVH

// opcodes; read and write keys skip bit 3, which carries address bit 8
`define EE_KEY_READ        7'h03
`define EE_KEY_WRITE       7'h02
`define EE_OP_LATCH_SET    8'h06
`define EE_OP_LATCH_CLR    8'h04
`define EE_OP_STATUS_RD    8'h05
`define EE_OP_STATUS_WR    8'h01
`define EE_OP_A8_BIT       3

// array geometry
`define EE_ADDR_BITS       9
`define EE_ARRAY_BYTES     512
`define EE_PAGE_BYTES      16
`define EE_PAGE_BITS       4

// status byte layout
`define EE_SR_BP_LSB       2
`define EE_BP_RST          2'h0

// timing
`define EE_CLK_NS          8
`define EE_TWC_NS          5000000
`define EE_TWC_CYC         (`EE_TWC_NS / `EE_CLK_NS)
`define EE_TMR_BITS        20

// pin levels while nothing is selected: cs_n, sck, si, hold_n, wp_n
`define EE_PINS_IDLE       5'h13

`endif

// [ee_pkg.sv]
`include "ee_map.svh"

package ee_pkg;

  typedef enum logic [2:0] {
    EE_IDLE  = 3'h0,
    EE_OPC   = 3'h1,
    EE_ADDR  = 3'h3,
    EE_RDATA = 3'h2,
    EE_WDATA = 3'h6,
    EE_SRD   = 3'h7,
    EE_SWR   = 3'h5,
    EE_SKIP  = 3'h4
  } ee_state_e;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_READ,
    CMD_WRITE,
    CMD_LATCH_SET,
    CMD_LATCH_CLR,
    CMD_STATUS_RD,
    CMD_STATUS_WR
  } ee_cmd_e;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } ee_pins_s;

  typedef struct packed {
    logic       protect_pin_enable;
    logic [2:0] spare;
    logic       block_protect_hi;
    logic       block_protect_lo;
    logic       latch_state_bit;
    logic       busy_bit;
  } ee_status_s;

endpackage : ee_pkg

// [ee_spi_core.sv]
`timescale 1ns/1ps
`include "ee_map.svh"
// Operation
// - input sampled msb first on sck rise
// - six opcodes decoded from the first byte
// - read opcode, address, then stored byte out
// - pointer increments after every byte read
// - pointer wraps from top to zero
// - select high ends read, output stops
// - latch set on select rise after eight bits
// - write chained after set leaves latch clear
// - each write replaces bytes, no erase needed
// - write opcode, address, up to one page
// - write data wraps inside current page
// - write starts only on byte-aligned select rise
// - array reads refused while write cycle runs
// - finished write cycle clears the latch
// - set and clear commands; write needs latch
// - latch clear at reset and after writes
// - protect pin low clears the latch
// - status byte layout, bit 7 absent here
// - busy bit follows the internal write cycle
// - latch bit mirrors latch, set/clear ignored during write cycle
// - block-protect bits changed by status write
// - status readable at any time

module ee_spi_core #(
  parameter int unsigned TWC_CYCLES = `EE_TWC_CYC
) (
  // system
  input  wire logic clk,
  input  wire logic srst,
  // serial link pins
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic hold_n,
  input  wire logic wp_n,
  // serial output pin
  output wire logic so,
  output wire logic so_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge events

  ee_pkg::ee_pins_s pins_in;
  ee_pkg::ee_pins_s pins1_r;
  ee_pkg::ee_pins_s pins2_r;
  ee_pkg::ee_pins_s pins3_r;

  assign pins_in = '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n, wp_n: wp_n};

  always_ff @(posedge clk) begin
    if (srst) begin
      pins1_r <= ee_pkg::ee_pins_s'(`EE_PINS_IDLE);
      pins2_r <= ee_pkg::ee_pins_s'(`EE_PINS_IDLE);
      pins3_r <= ee_pkg::ee_pins_s'(`EE_PINS_IDLE);
    end else begin
      pins1_r <= pins_in;
      pins2_r <= pins1_r;
      pins3_r <= pins2_r;
    end
  end

  logic sel;
  logic held;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic byte_done;

  // pause gates the clock edges and the output enable; select keeps working while paused
  assign sel      = !pins2_r.cs_n;
  assign held     = !pins2_r.hold_n;
  assign sck_rise = sel && !held && pins2_r.sck && !pins3_r.sck;
  assign sck_fall = sel && !held && !pins2_r.sck && pins3_r.sck;
  assign cs_rise  = pins2_r.cs_n && !pins3_r.cs_n;
  assign cs_fall  = !pins2_r.cs_n && pins3_r.cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // input shifter

  logic [2:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;

  assign sh_nxt    = {sh_r[6:0], pins2_r.si};
  assign byte_done = sck_rise && (bit_cnt_r == 3'h7);

  always_ff @(posedge clk) begin
    if (srst || cs_fall) begin
      bit_cnt_r <= 3'h0;
      sh_r      <= 8'h00;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      sh_r      <= sh_nxt;
    end
  end

  function automatic ee_pkg::ee_cmd_e cmd_of(input logic [7:0] op);
    logic [6:0] key;
    key = {op[7:4], op[2:0]};
    if (key == `EE_KEY_READ) return ee_pkg::CMD_READ;
    if (key == `EE_KEY_WRITE) return ee_pkg::CMD_WRITE;
    if (op == `EE_OP_LATCH_SET) return ee_pkg::CMD_LATCH_SET;
    if (op == `EE_OP_LATCH_CLR) return ee_pkg::CMD_LATCH_CLR;
    if (op == `EE_OP_STATUS_RD) return ee_pkg::CMD_STATUS_RD;
    if (op == `EE_OP_STATUS_WR) return ee_pkg::CMD_STATUS_WR;
    return ee_pkg::CMD_NONE;
  endfunction : cmd_of

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer

  ee_pkg::ee_state_e state_r;
  ee_pkg::ee_cmd_e   cmd_r;
  ee_pkg::ee_cmd_e   cmd_nxt;
  logic              a8_r;
  logic              got_r;
  logic              extra_r;
  logic              busy_r;

  // during a write cycle everything but a status read is dropped
  assign cmd_nxt = (busy_r && cmd_of(sh_nxt) != ee_pkg::CMD_STATUS_RD)
                   ? ee_pkg::CMD_NONE : cmd_of(sh_nxt);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ee_pkg::EE_IDLE;
      cmd_r   <= ee_pkg::CMD_NONE;
      a8_r    <= 1'b0;
      got_r   <= 1'b0;
      extra_r <= 1'b0;
    end else if (!sel) begin
      state_r <= ee_pkg::EE_IDLE;
    end else if (cs_fall) begin
      state_r <= ee_pkg::EE_OPC;
      cmd_r   <= ee_pkg::CMD_NONE;
      got_r   <= 1'b0;
      extra_r <= 1'b0;
    end else if (byte_done) begin
      unique case (state_r)
        ee_pkg::EE_OPC: begin
          cmd_r <= cmd_nxt;
          a8_r  <= sh_nxt[`EE_OP_A8_BIT];
          unique case (cmd_nxt)
            ee_pkg::CMD_READ,
            ee_pkg::CMD_WRITE:     state_r <= ee_pkg::EE_ADDR;
            ee_pkg::CMD_STATUS_RD: state_r <= ee_pkg::EE_SRD;
            ee_pkg::CMD_STATUS_WR: state_r <= ee_pkg::EE_SWR;
            default:               state_r <= ee_pkg::EE_SKIP;
          endcase
        end
        ee_pkg::EE_ADDR: begin
          state_r <= (cmd_r == ee_pkg::CMD_READ) ? ee_pkg::EE_RDATA : ee_pkg::EE_WDATA;
        end
        ee_pkg::EE_WDATA: got_r <= 1'b1;
        ee_pkg::EE_SWR: begin
          if (got_r) extra_r <= 1'b1;
          got_r <= 1'b1;
        end
        ee_pkg::EE_SKIP: extra_r <= 1'b1;
        default: state_r <= state_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address pointer, array and page buffer

  logic [`EE_ADDR_BITS-1:0] ptr_r;
  logic [`EE_ADDR_BITS-1:0] ptr_inc;
  logic [7:0]               mem_r  [`EE_ARRAY_BYTES];
  logic [7:0]               page_r [`EE_PAGE_BYTES];
  logic [`EE_PAGE_BYTES-1:0] mask_r;
  logic                     commit;
  logic                     latch_r;

  assign ptr_inc = ptr_r + 9'h001;

  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_r <= 9'h000;
    end else if (byte_done && state_r == ee_pkg::EE_ADDR) begin
      ptr_r <= {a8_r, sh_nxt};
    end else if (byte_done && state_r == ee_pkg::EE_RDATA) begin
      ptr_r <= ptr_inc;
    end else if (byte_done && state_r == ee_pkg::EE_WDATA) begin
      ptr_r <= {ptr_r[8:4], ptr_r[3:0] + 4'h1};
    end
  end
  always_ff @(posedge clk) begin
    if (srst || cs_fall) begin
      mask_r <= 16'h0000;
    end else if (byte_done && state_r == ee_pkg::EE_WDATA) begin
      mask_r[ptr_r[3:0]] <= 1'b1;
    end
  end
  // data storage holds no reset: its contents survive like the cells they stand for
  always_ff @(posedge clk) begin
    if (byte_done && state_r == ee_pkg::EE_WDATA) begin
      page_r[ptr_r[3:0]] <= sh_nxt;
    end
  end

  // aligned select rise after a whole data byte, latch set
  assign commit = cs_rise && state_r == ee_pkg::EE_WDATA && bit_cnt_r == 3'h0
                  && got_r && latch_r;

  // whole bytes are replaced, so no erase step precedes the write
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < `EE_PAGE_BYTES; i++) begin
        if (mask_r[i]) begin
          mem_r[{ptr_r[8:4], 4'(i)}] <= page_r[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write cycle timer, latch and status

  logic [`EE_TMR_BITS-1:0] tmr_r;
  logic [1:0]              bp_r;
  logic [7:0]              sw_data_r;
  logic                    sw_commit;
  logic                    cyc_end;
  logic                    latch_cmd;
  ee_pkg::ee_status_s      status_w;

  assign sw_commit = cs_rise && state_r == ee_pkg::EE_SWR && bit_cnt_r == 3'h0
                     && got_r && !extra_r && latch_r;
  assign cyc_end   = busy_r && tmr_r == 20'h00000;
  // one opcode byte, then select high with no further bits
  assign latch_cmd = cs_rise && state_r == ee_pkg::EE_SKIP && bit_cnt_r == 3'h0
                     && !extra_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      tmr_r  <= 20'h00000;
    end else if (commit || sw_commit) begin
      busy_r <= 1'b1;
      tmr_r  <= 20'(TWC_CYCLES - 1);
    end else if (cyc_end) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      tmr_r <= tmr_r - 20'h00001;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      latch_r <= 1'b0;
    end else if (!pins2_r.wp_n) begin
      latch_r <= 1'b0;
    end else if (cyc_end) begin
      latch_r <= 1'b0;
    end else if (latch_cmd && cmd_r == ee_pkg::CMD_LATCH_SET) begin
      latch_r <= 1'b1;
    end else if (latch_cmd && cmd_r == ee_pkg::CMD_LATCH_CLR) begin
      latch_r <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      sw_data_r <= 8'h00;
    end else if (byte_done && state_r == ee_pkg::EE_SWR && !got_r) begin
      sw_data_r <= sh_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      bp_r <= `EE_BP_RST;
    end else if (sw_commit) begin
      bp_r <= sw_data_r[`EE_SR_BP_LSB +: 2];
    end
  end
  // no pin-enable bit at this density, so bit 7 reads zero
  assign status_w = '{protect_pin_enable: 1'b0, spare: 3'h0,
                      block_protect_hi: bp_r[1], block_protect_lo: bp_r[0],
                      latch_state_bit: latch_r, busy_bit: busy_r};

  ////////////////////////////////////////////////////////////////////////////
  // output shifter; data changes on falling sck so the host samples it stable

  logic [7:0] out_r;
  logic       so_r;
  logic       so_oe_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      out_r <= 8'h00;
    end else if (byte_done) begin
      unique case (state_r)
        ee_pkg::EE_ADDR:  out_r <= mem_r[{a8_r, sh_nxt}];
        ee_pkg::EE_RDATA: out_r <= mem_r[ptr_inc];
        default:          out_r <= status_w;
      endcase
    end else if (sck_fall) begin
      out_r <= {out_r[6:0], 1'b0};
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      so_r <= 1'b0;
    end else if (sck_fall) begin
      so_r <= out_r[7];
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      so_oe_r <= 1'b0;
    end else begin
      so_oe_r <= sel && !held
                 && (state_r == ee_pkg::EE_RDATA || state_r == ee_pkg::EE_SRD);
    end
  end

  assign so    = so_r;
  assign so_oe = so_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence set_taken_s;
    latch_cmd && cmd_r == ee_pkg::CMD_LATCH_SET && pins2_r.wp_n && !cyc_end;
  endsequence
  sequence cycle_start_s;
    $rose(busy_r);
  endsequence

  oe_idle_a: assert property (pins2_r.cs_n |=> !so_oe_r)
    else $error("output enabled while deselected");
  latch_set_a: assert property (set_taken_s |=> latch_r)
    else $error("latch not set after set command");
  latch_gate_a: assert property (cycle_start_s |-> $past(latch_r))
    else $error("write cycle started without latch");
  align_start_a: assert property (cycle_start_s |-> $past(bit_cnt_r) == 3'h0)
    else $error("write cycle started off a byte boundary");
  busy_hold_a: assert property (cycle_start_s |-> busy_r [*8])
    else $error("busy dropped too early");
  latch_end_a: assert property ($fell(busy_r) |-> !latch_r)
    else $error("latch still set after write cycle");
  read_refuse_a: assert property (busy_r |-> state_r != ee_pkg::EE_RDATA
                                  && state_r != ee_pkg::EE_ADDR)
    else $error("array access during write cycle");
  ptr_step_a: assert property (byte_done && state_r == ee_pkg::EE_RDATA
                               |=> ptr_r == $past(ptr_inc))
    else $error("read pointer did not advance");
  page_keep_a: assert property (byte_done && state_r == ee_pkg::EE_WDATA
                                |=> ptr_r[8:4] == $past(ptr_r[8:4]))
    else $error("write pointer left its page");
  wp_clear_a: assert property (!pins2_r.wp_n |=> !latch_r)
    else $error("latch survived protect pin low");
  status_busy_a: assert property (byte_done && state_r == ee_pkg::EE_SRD
                                  |=> out_r[0] == $past(busy_r))
    else $error("status byte lost busy bit");

endmodule : ee_spi_core

// [ee_host_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module ee_host_model (
  // system
  input  wire logic clk,
  // link pins driven towards the device
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si,
  // link pins from the device
  input  wire logic so,
  input  wire logic so_oe
);

  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // all pin changes land 1 ns after a clk edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic start();
    tick(1);
    cs_n = 1'b0;
    tick(5);
  endtask : start

  // shifts nb bits of tx msb first; oe is low if so_oe dropped at any sample
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx,
                      output logic oe);
    rx = 8'h00;
    oe = 1'b1;
    for (int i = 7; i > 7 - nb; i--) begin
      si = tx[i];
      tick(5);
      sck   = 1'b1;
      // a released line has no pull, so it is read as the inverse of so
      rx[i] = so_oe ? so : ~so;
      oe    = oe & so_oe;
      tick(5);
      sck = 1'b0;
    end
  endtask : xfer

  // select rises only after sck has settled low; released si toggles
  task automatic stop();
    tick(5);
    cs_n = 1'b1;
    si   = ~si;
    tick(12);
  endtask : stop

endmodule : ee_host_model

// [ee_spi_core_test.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module ee_spi_core_test;

  logic       clk = 1'b0;
  logic       srst;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       hold_n;
  logic       wp_n;
  logic       so;
  logic       so_oe;
  int         fails;
  int         n_checks;
  logic [7:0] st;
  logic [7:0] rb [4];
  logic       oe;
  // address beside the byte that reading it back must give
  logic [16:0] rows [5] = '{{9'h1FF, 8'hA5}, {9'h000, 8'h3C}, {9'h100, 8'h81},
                            {9'h0A5, 8'hFF}, {9'h07F, 8'h00}};

  always #4 clk = ~clk;

  ee_spi_core #(.TWC_CYCLES(2000)) dut (
    .clk(clk), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe)
  );

  ee_host_model host (
    .clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe)
  );

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    logic       o;
    host.start();
    host.xfer(op, 8, r, o);
    host.stop();
  endtask : cmd

  task automatic status(output logic [7:0] s);
    logic [7:0] r;
    logic       o;
    host.start();
    host.xfer(8'h05, 8, r, o);
    host.xfer(8'h00, 8, s, o);
    host.stop();
  endtask : status

  // polls busy; each poll is far longer than a clk, so 40 is ample
  task automatic wait_idle();
    logic [7:0] s;
    for (int i = 0; i < 40; i++) begin
      status(s);
      if (s[0] === 1'b0) return;
    end
    fails++;
    $display("timeout waiting for write cycle");
    complete_run();
  endtask : wait_idle

  // n bytes first, first+1, ... then tail stray bits
  task automatic wr(input logic [8:0] a, input int n, input logic [7:0] first, input int tail);
    logic [7:0] r;
    logic       o;
    host.start();
    host.xfer({4'h0, a[8], 3'h2}, 8, r, o);
    host.xfer(a[7:0], 8, r, o);
    for (int i = 0; i < n; i++) host.xfer(first + 8'(i), 8, r, o);
    if (tail > 0) host.xfer(8'hFF, tail, r, o);
    host.stop();
  endtask : wr

  task automatic rd(input logic [8:0] a, input int n, output logic oe_all);
    logic [7:0] r;
    logic       o;
    host.start();
    host.xfer({4'h0, a[8], 3'h3}, 8, r, o);
    host.xfer(a[7:0], 8, r, o);
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      host.xfer(8'h00, 8, rb[i], o);
      oe_all = oe_all & o;
    end
    host.stop();
  endtask : rd

  ////////////////////////////////////////////////////////////
  initial begin
    srst     = 1'b1;
    hold_n   = 1'b1;
    wp_n     = 1'b1;
    fails    = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    #1;
    srst = 1'b0;
    status(st);
    check(st, 8'h00);
    check({7'h0, so_oe}, 8'h00);
    $display("test reset done");

    foreach (rows[i]) begin
      cmd(8'h06);
      wr(rows[i][16:8], 1, rows[i][7:0], 0);
      wait_idle();
      rd(rows[i][16:8], 1, oe);
      check(rb[0], rows[i][7:0]);
      check({7'h0, oe}, 8'h01);
    end
    $display("test table done");

    cmd(8'h06);
    status(st);
    check(st, 8'h02);
    cmd(8'h04);
    status(st);
    check(st, 8'h00);
    $display("test latch done");

    // write chained behind a latch set in one frame
    host.start();
    host.xfer(8'h06, 8, rb[3], oe);
    host.xfer(8'h02, 8, rb[3], oe);
    host.xfer(8'h00, 8, rb[3], oe);
    host.xfer(8'h55, 8, rb[3], oe);
    host.stop();
    status(st);
    check(st, 8'h00);
    rd(9'h000, 1, oe);
    check(rb[0], 8'h3C);
    $display("test chained done");

    cmd(8'h06);
    wr(9'h0FE, 4, 8'h10, 0);
    status(st);
    check(st, 8'h03);
    rd(9'h0F0, 1, oe);
    check({7'h0, oe}, 8'h00);
    wait_idle();
    status(st);
    check(st, 8'h00);
    rd(9'h0F0, 2, oe);
    check(rb[0], 8'h12);
    check(rb[1], 8'h13);
    rd(9'h0FE, 2, oe);
    check(rb[0], 8'h10);
    check(rb[1], 8'h11);
    $display("test page wrap done");

    rd(9'h1FF, 2, oe);
    check(rb[0], 8'hA5);
    check(rb[1], 8'h3C);
    check({7'h0, so_oe}, 8'h00);
    $display("test read wrap done");

    // pause mid-read; clocks while paused must not move the stream
    host.start();
    host.xfer(8'h03, 8, rb[3], oe);
    host.xfer(8'h00, 8, rb[3], oe);
    host.tick(4);
    hold_n = 1'b0;
    host.tick(4);
    check({7'h0, so_oe}, 8'h00);
    host.xfer(8'hFF, 8, rb[3], oe);
    check({7'h0, oe}, 8'h00);
    host.tick(4);
    hold_n = 1'b1;
    host.tick(4);
    host.xfer(8'h00, 8, rb[2], oe);
    check(rb[2], 8'h3C);
    host.stop();
    $display("test pause done");

    cmd(8'h06);
    wr(9'h0A5, 1, 8'h77, 3);
    status(st);
    check({7'h0, st[0]}, 8'h00);
    rd(9'h0A5, 1, oe);
    check(rb[0], 8'hFF);
    cmd(8'h04);
    $display("test abandon done");

    cmd(8'h06);
    wp_n = 1'b0;
    host.tick(4);
    wp_n = 1'b1;
    host.tick(4);
    status(st);
    check(st, 8'h00);
    $display("test protect pin done");

    cmd(8'h06);
    host.start();
    host.xfer(8'h01, 8, rb[3], oe);
    host.xfer(8'h0C, 8, rb[3], oe);
    host.stop();
    wait_idle();
    status(st);
    check(st, 8'h0C);
    $display("test status write done");
    complete_run();
  end

endmodule : ee_spi_core_test
